// ### sdl_framer.sv
// ****************************************************************
// shared constants and types
// ****************************************************************
package sdl_pkg;

    // frame shape
    localparam int DATA_BITS = 24;
    localparam int FRAME_BITS = 28;
    localparam logic [4:0] FRAME_LAST = 5'd27;
    localparam logic [4:0] FRAME_MID = 5'd13;
    localparam logic [7:0] DATA_BITS_S = 8'sd24;

    // frame positions once the whole frame sits in the receive shifter
    localparam int POS_HIGH = 0;
    localparam int POS_DATA_LO = 1;
    localparam int POS_DATA_HI = 24;
    localparam int POS_INTEG = 25;
    localparam int POS_BAL = 26;
    localparam int POS_LOW = 27;

    // register map, byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam int CTRL_WIDTH = 6;

    // status field positions
    localparam int ST_TX_LOCK = 0;
    localparam int ST_RX_LOCK = 1;
    localparam int ST_SUPPLY = 2;
    localparam int ST_LOSS_LO = 8;
    localparam int ST_DROP_LO = 16;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TRANSMIT_CLOCK_LOSS_NS = 2000;
    localparam logic [7:0] TRANSMIT_CLOCK_LOSS_CYC = 8'(TRANSMIT_CLOCK_LOSS_NS / CLK_PERIOD_NS);
    localparam logic [2:0] TX_LOCK_EDGES = 3'd4;
    localparam logic [2:0] RX_LOCK_FRAMES = 3'd4;

    // control bits, bit 0 is tx_output_enable
    typedef struct packed {
        logic rx_edge_select;
        logic rx_powerdown_n;
        logic rx_output_enable;
        logic tx_edge_select;
        logic tx_powerdown_n;
        logic tx_output_enable;
    } sdl_ctrl_type;

    typedef enum logic [1:0] {TX_OFF, TX_ACQ, TX_LOCKED} sdl_tx_state_type;
    typedef enum logic [1:0] {RX_SEARCH, RX_VERIFY, RX_LOCKED} sdl_rx_state_type;

    // number of ones in a data word
    function automatic logic [4:0] sdl_ones(input logic [DATA_BITS-1:0] w);
        logic [4:0] n;
        n = 5'd0;
        for (int i = 0; i < DATA_BITS; i++) begin
            n = n + 5'(w[i]);
        end
        return n;
    endfunction : sdl_ones

endpackage : sdl_pkg

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// frame builder and bit shifter
// ****************************************************************
module sdl_framer
    import sdl_pkg::*;
(
    input wire logic clk, // block clock
    input wire logic reset, // synchronous, active high
    input wire logic run, // transmitter locked and powered
    input wire logic [DATA_BITS-1:0] word, // latest captured word
    output logic take, // pulse: word loaded into a frame
    output logic bit_p, // true serial bit
    output logic bit_n // inverted serial bit
);

    typedef struct packed {
        logic [FRAME_BITS-2:0] sh;
        logic [4:0] cnt;
        logic busy;
        logic signed [7:0] rd;
        logic bp;
        logic bn;
        logic take;
    } sdl_fr_type;

    sdl_fr_type q, d;

    // next state of the shifter
    always_comb begin
        logic signed [7:0] diff;
        logic inv;
        logic [DATA_BITS-1:0] field;
        logic [FRAME_BITS-1:0] fr;
        diff = '0;
        inv = 1'b0;
        field = '0;
        fr = '0;
        d = q;
        d.take = 1'b0;
        if (!run) begin
            d.busy = 1'b0;
            d.cnt = '0;
            d.bp = 1'b0;
            d.bn = 1'b1;
        end else if (!q.busy || q.cnt == FRAME_LAST) begin
            // frames follow back to back, repeating the last word if none is new
            diff = signed'({2'b00, sdl_ones(word), 1'b0}) - DATA_BITS_S;
            inv = (q.rd > 0 && diff > 0) || (q.rd < 0 && diff < 0);
            field = inv ? ~word : word;
            d.rd = inv ? q.rd - diff : q.rd + diff;
            fr = {1'b0, inv, ^field, field, 1'b1};
            d.bp = fr[0];
            d.bn = ~fr[0];
            d.sh = fr[FRAME_BITS-1:1];
            d.cnt = '0;
            d.busy = 1'b1;
            d.take = 1'b1;
        end else begin
            // one bit a clock, low bit first
            d.bp = q.sh[0];
            d.bn = ~q.sh[0];
            d.sh = {1'b0, q.sh[FRAME_BITS-2:1]};
            d.cnt = q.cnt + 5'd1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '0;
            q.bn <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign take = q.take;
    assign bit_p = q.bp;
    assign bit_n = q.bn;

endmodule : sdl_framer

`default_nettype wire

// ### sdl_serdes_link.sv
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module sdl_serdes_link
    import sdl_pkg::*;
#(
    parameter logic [7:0] LOSS_CYC = TRANSMIT_CLOCK_LOSS_CYC, // clocks without a transmit clock edge
    parameter logic [2:0] LOCK_EDGES = TX_LOCK_EDGES, // edges to gain transmit lock
    parameter logic [2:0] LOCK_FRAMES = RX_LOCK_FRAMES // good frames to gain receive lock
) (
    input wire logic CLK, // block clock
    input wire logic RESET, // synchronous, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error, unmapped address
    input wire logic SUPPLY_OK, // supply above its good threshold
    input wire logic TRANSMIT_CLOCK, // transmit word clock from source
    input wire logic [DATA_BITS-1:0] TX_PARALLEL_IN, // transmit data word
    output logic TX_SERIAL_P, // serial line, true
    output logic TX_SERIAL_N, // serial line, inverted
    output logic TX_SERIAL_OE_N, // low while serial pair driven
    input wire logic SERIAL_LINE_IN, // incoming serial line
    output logic [DATA_BITS-1:0] RX_PARALLEL_OUT, // recovered data word
    output logic RX_CLK_OUT, // recovered word clock
    output logic RX_OUT_OE_N, // low while data and clock driven
    output logic RX_LOCK // receive lock indicator
);

    // ****************************************************************
    // state
    // ****************************************************************

    typedef struct packed {
        logic sup_s1;
        logic sup_s2;
        logic tck_s1;
        logic tck_s2;
        logic tck_s3;
        logic [DATA_BITS-1:0] din_s1;
        logic [DATA_BITS-1:0] din_s2;
        logic ser_s1;
        logic ser_s2;
        sdl_ctrl_type ctrl;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        sdl_tx_state_type tx_st;
        logic [2:0] tx_edges;
        logic [7:0] tx_gap;
        logic tx_sel_seen;
        logic [DATA_BITS-1:0] tx_word;
        logic tx_pend;
        logic [7:0] drops;
        logic tx_oe_n;
        sdl_rx_state_type rx_st;
        logic [FRAME_BITS-1:0] sr;
        logic [4:0] bitcnt;
        logic [2:0] good;
        logic [DATA_BITS-1:0] rx_data;
        logic rclk;
        logic lock;
        logic [7:0] losses;
        logic rx_oe_n;
    } sdl_state_type;

    sdl_state_type q, d;
    logic fr_take;
    logic fr_p;
    logic fr_n;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // markers in place and integrity bit matches the field
    function automatic logic frame_ok(input logic [FRAME_BITS-1:0] f);
        return f[POS_HIGH] && !f[POS_LOW]
            && (f[POS_INTEG] == ^f[POS_DATA_HI:POS_DATA_LO]);
    endfunction : frame_ok

    // register read decode
    function automatic logic [31:0] read_word(input sdl_state_type s, input logic [11:0] a);
        logic [31:0] w;
        w = 32'h00000000;
        if (a == ADDR_CTRL) begin
            w[CTRL_WIDTH-1:0] = s.ctrl;
        end else if (a == ADDR_STATUS) begin
            w[ST_TX_LOCK] = (s.tx_st == TX_LOCKED);
            w[ST_RX_LOCK] = s.lock;
            w[ST_SUPPLY] = s.sup_s2;
            w[ST_LOSS_LO +: 8] = s.losses;
            w[ST_DROP_LO +: 8] = s.drops;
        end
        return w;
    endfunction : read_word

    // ****************************************************************
    // next state
    // ****************************************************************

    always_comb begin
        logic tx_en;
        logic rx_en;
        logic any_edge;
        logic sel_edge;
        logic capture;
        logic [FRAME_BITS-1:0] sr_n;
        tx_en = 1'b0;
        rx_en = 1'b0;
        any_edge = 1'b0;
        sel_edge = 1'b0;
        capture = 1'b0;
        sr_n = '0;
        d = q;

        // two-stage synchronisers for every outside input except the apb bus and reset
        d.sup_s1 = SUPPLY_OK;
        d.sup_s2 = q.sup_s1;
        d.tck_s1 = TRANSMIT_CLOCK;
        d.tck_s2 = q.tck_s1;
        d.tck_s3 = q.tck_s2;
        d.din_s1 = TX_PARALLEL_IN;
        d.din_s2 = q.din_s1;
        d.ser_s1 = SERIAL_LINE_IN;
        d.ser_s2 = q.ser_s1;

        // apb: answer prepared in setup, ready in the access phase
        d.pready = PSEL && !PENABLE;
        if (PSEL && !PENABLE) begin
            d.prdata = read_word(q, PADDR);
            d.pslverr = (PADDR != ADDR_CTRL) && (PADDR != ADDR_STATUS);
        end
        if (PSEL && PENABLE && q.pready && PWRITE && PADDR == ADDR_CTRL) begin
            d.ctrl = sdl_ctrl_type'(PWDATA[CTRL_WIDTH-1:0]);
        end

        // ************************************************************
        // transmit lock
        // ************************************************************

        tx_en = q.sup_s2 && q.ctrl.tx_powerdown_n;
        any_edge = q.tck_s2 ^ q.tck_s3;
        sel_edge = q.ctrl.tx_edge_select ? (q.tck_s2 && !q.tck_s3)
                                         : (!q.tck_s2 && q.tck_s3);

        // gap timer watches the source clock for a missing edge
        d.tx_gap = any_edge ? 8'h00 : q.tx_gap + 8'h01;

        unique case (q.tx_st)
            TX_OFF: begin
                d.tx_edges = '0;
                d.tx_gap = '0;
                if (tx_en) begin
                    d.tx_st = TX_ACQ;
                end
            end
            TX_ACQ: begin
                if (any_edge) begin
                    d.tx_edges = q.tx_edges + 3'd1;
                    if (q.tx_edges == LOCK_EDGES - 3'd1) begin
                        d.tx_st = TX_LOCKED;
                    end
                end else if (q.tx_gap == LOSS_CYC) begin
                    d.tx_edges = '0;
                end
            end
            TX_LOCKED: begin
                if (!any_edge && q.tx_gap == LOSS_CYC) begin
                    d.tx_st = TX_ACQ;
                    d.tx_edges = '0;
                end
            end
        endcase

        // a new edge choice needs a fresh lock; output enable does not
        d.tx_sel_seen = q.ctrl.tx_edge_select;
        if (q.tx_st != TX_OFF && q.tx_sel_seen != q.ctrl.tx_edge_select) begin
            d.tx_st = TX_ACQ;
            d.tx_edges = '0;
        end
        if (!tx_en) begin
            d.tx_st = TX_OFF;
        end

        // word capture once locked; an unsent word that is replaced counts as dropped
        capture = (q.tx_st == TX_LOCKED) && sel_edge;
        if (capture) begin
            d.tx_word = q.din_s2;
            d.tx_pend = 1'b1;
            if (q.tx_pend && !fr_take && q.drops != 8'hff) begin
                d.drops = q.drops + 8'h01;
            end
        end else if (fr_take) begin
            d.tx_pend = 1'b0;
        end

        // serial drive only when locked, enabled and powered
        d.tx_oe_n = !(d.tx_st == TX_LOCKED && q.ctrl.tx_output_enable && tx_en);

        // ************************************************************
        // receive alignment and lock
        // ************************************************************

        rx_en = q.sup_s2 && q.ctrl.rx_powerdown_n;
        sr_n = {q.ser_s2, q.sr[FRAME_BITS-1:1]};

        if (!rx_en) begin
            // serial input ignored, alignment lost
            d.rx_st = RX_SEARCH;
            d.lock = 1'b0;
            d.rclk = 1'b0;
            d.bitcnt = '0;
            d.good = '0;
        end else begin
            d.sr = sr_n;
            unique case (q.rx_st)
                RX_SEARCH: begin
                    // slide one bit a clock until any frame fits
                    if (frame_ok(sr_n)) begin
                        d.rx_st = RX_VERIFY;
                        d.bitcnt = '0;
                        d.good = 3'd1;
                    end
                end
                RX_VERIFY, RX_LOCKED: begin
                    if (q.bitcnt == FRAME_LAST) begin
                        d.bitcnt = '0;
                        if (!frame_ok(sr_n)) begin
                            // a single missed marker drops lock
                            d.rx_st = RX_SEARCH;
                            d.lock = 1'b0;
                            d.rclk = 1'b0;
                            if (q.rx_st == RX_LOCKED && q.losses != 8'hff) begin
                                d.losses = q.losses + 8'h01;
                            end
                        end else begin
                            if (q.rx_st == RX_VERIFY) begin
                                d.good = q.good + 3'd1;
                            end
                            if (q.rx_st == RX_LOCKED || q.good == LOCK_FRAMES - 3'd1) begin
                                // lock and first word appear together
                                d.rx_st = RX_LOCKED;
                                d.lock = 1'b1;
                                d.rx_data = sr_n[POS_DATA_HI:POS_DATA_LO]
                                    ^ {DATA_BITS{sr_n[POS_BAL]}};
                                d.rclk = !q.ctrl.rx_edge_select;
                            end
                        end
                    end else begin
                        d.bitcnt = q.bitcnt + 5'd1;
                        if (q.rx_st == RX_LOCKED && q.bitcnt == FRAME_MID) begin
                            // strobing edge lands mid-word
                            d.rclk = q.ctrl.rx_edge_select;
                        end
                    end
                end
                default: begin
                    d.rx_st = RX_SEARCH;
                end
            endcase
        end

        // data and clock driven only while locked and enabled
        d.rx_oe_n = !(d.lock && q.ctrl.rx_output_enable && rx_en);
    end

    // ****************************************************************
    // registers
    // ****************************************************************

    always_ff @(posedge CLK) begin
        if (RESET) begin
            q <= '0;
            q.ctrl <= sdl_ctrl_type'(CTRL_RESET);
            q.tx_oe_n <= 1'b1;
            q.rx_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // frame builder
    // ****************************************************************

    sdl_framer u_framer (
        .clk(CLK),
        .reset(RESET),
        .run(q.tx_st == TX_LOCKED),
        .word(q.tx_word),
        .take(fr_take),
        .bit_p(fr_p),
        .bit_n(fr_n)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************

    assign PRDATA = q.prdata;
    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign TX_SERIAL_P = fr_p;
    assign TX_SERIAL_N = fr_n;
    assign TX_SERIAL_OE_N = q.tx_oe_n;
    assign RX_PARALLEL_OUT = q.rx_data;
    assign RX_CLK_OUT = q.rclk;
    assign RX_OUT_OE_N = q.rx_oe_n;
    assign RX_LOCK = q.lock;

endmodule : sdl_serdes_link

`default_nettype wire

// ### sdl_far_end.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// far side: word source with its clock, serial line loopback
// ****************************************************************
module sdl_far_end
    import sdl_pkg::*;
(
    input wire logic clk, // block clock
    input wire logic ser_p, // serial bit from the transmitter
    input wire logic ser_oe_n, // low while the transmitter drives
    input wire logic flip, // invert the line while high
    input wire logic [DATA_BITS-1:0] word_hi, // word while word clock high
    input wire logic [DATA_BITS-1:0] word_lo, // word while word clock low
    output logic transmit_clock, // transmit word clock
    output logic [DATA_BITS-1:0] data, // transmit data word
    output logic ser_in // line seen by the receiver
);
    logic last;

    // free-running word clock, phase unrelated to the block clock
    initial begin
        transmit_clock = 1'b0;
        #137;
        forever #400 transmit_clock = ~transmit_clock;
    end

    // ordinary words that switch with the clock edge, no training pattern
    assign data = transmit_clock ? word_hi : word_lo;

    // loopback in send order; released line shows inverse of last bit
    initial begin
        last = 1'b0;
        ser_in = 1'b0;
    end
    always @(posedge clk) begin
        if (!ser_oe_n) begin
            last <= ser_p;
        end
        ser_in <= ser_oe_n ? ~last : (ser_p ^ flip);
    end
endmodule : sdl_far_end

`default_nettype wire

// ### sdl_link_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// link checker
// ****************************************************************
module sdl_link_sva
    import sdl_pkg::*;
(
    input wire logic CLK, // block clock
    input wire logic RESET, // synchronous reset
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb address
    input wire logic [31:0] PRDATA, // apb read data
    input wire logic PREADY, // apb ready
    input wire logic PSLVERR, // apb error
    input wire logic SUPPLY_OK, // supply good
    input wire logic TX_SERIAL_P, // serial true
    input wire logic TX_SERIAL_N, // serial inverted
    input wire logic TX_SERIAL_OE_N, // serial drive enable
    input wire logic [DATA_BITS-1:0] RX_PARALLEL_OUT, // recovered word
    input wire logic RX_CLK_OUT, // recovered clock
    input wire logic RX_OUT_OE_N, // receive drive enable
    input wire logic RX_LOCK // receive lock
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // serial pair always complementary
    property p_pair;
        TX_SERIAL_N == !TX_SERIAL_P;
    endproperty
    a_pair: assert property (p_pair) else $error("serial pair not complementary");

    // receive outputs driven only while locked
    property p_oe_lock;
        !RX_OUT_OE_N |-> RX_LOCK;
    endproperty
    a_oe_lock: assert property (p_oe_lock) else $error("receive outputs on while unlocked");

    // a new word holds for the next 8 cycles while lock stays
    property p_word_hold;
        RX_LOCK && $changed(RX_PARALLEL_OUT) |=> (!RX_LOCK || $stable(RX_PARALLEL_OUT)) [*8];
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("receive word not held");

    // recovered clock edges 14 cycles apart
    property p_rclk_mid;
        RX_LOCK && $changed(RX_CLK_OUT) |-> ##14 (!RX_LOCK || $changed(RX_CLK_OUT));
    endproperty
    a_rclk_mid: assert property (p_rclk_mid) else $error("recovered clock edge misplaced");

    // supply loss turns both output enables off and drops lock soon
    property p_supply;
        $fell(SUPPLY_OK) |-> ##[1:6] (TX_SERIAL_OE_N && RX_OUT_OE_N && !RX_LOCK);
    endproperty
    a_supply: assert property (p_supply) else $error("outputs stay on after supply loss");

    // zero wait states
    property p_ready;
        PSEL && !PENABLE |=> PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("apb ready late");

    // error exactly for unmapped addresses
    property p_err;
        PREADY |-> PSLVERR == (PADDR != ADDR_CTRL && PADDR != ADDR_STATUS);
    endproperty
    a_err: assert property (p_err) else $error("apb error wrong");

    // unused control bits read zero
    property p_ctrl_rd;
        PREADY && !PWRITE && PADDR == ADDR_CTRL |-> PRDATA[31:CTRL_WIDTH] == '0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control upper bits not zero");
endmodule : sdl_link_sva

bind sdl_serdes_link sdl_link_sva chk (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA,
    .PREADY, .PSLVERR, .SUPPLY_OK, .TX_SERIAL_P, .TX_SERIAL_N, .TX_SERIAL_OE_N,
    .RX_PARALLEL_OUT, .RX_CLK_OUT, .RX_OUT_OE_N, .RX_LOCK);

`default_nettype wire

// ### sdl_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// link testbench
// ****************************************************************
module tb
    import sdl_pkg::*;
;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, supply_ok, flip, transmit_clock;
    logic ser_p, ser_n, ser_oe_n, ser_in, rx_clk, rx_oe_n, rx_lock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [DATA_BITS-1:0] tx_data, rx_data, word_hi, word_lo;
    int n_errors, check_count;

    sdl_serdes_link #(.LOCK_FRAMES(3'd2)) uut (.CLK(clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SUPPLY_OK(supply_ok), .TRANSMIT_CLOCK(transmit_clock),
        .TX_PARALLEL_IN(tx_data), .TX_SERIAL_P(ser_p), .TX_SERIAL_N(ser_n),
        .TX_SERIAL_OE_N(ser_oe_n), .SERIAL_LINE_IN(ser_in), .RX_PARALLEL_OUT(rx_data),
        .RX_CLK_OUT(rx_clk), .RX_OUT_OE_N(rx_oe_n), .RX_LOCK(rx_lock));

    sdl_far_end far (.clk(clk), .ser_p(ser_p), .ser_oe_n(ser_oe_n), .flip(flip),
        .word_hi(word_hi), .word_lo(word_lo), .transmit_clock(transmit_clock), .data(tx_data), .ser_in(ser_in));

    // block clock, 100 ns
    always #50 clk = ~clk;

    task complete_run;
        $display("comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check

    task timeout(input string name);
        n_errors++;
        $display("unexpected %s: expected completion, seen timeout", name);
        complete_run();
    endtask : timeout

    // one apb transfer, held until ready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (pready !== 1'b1) timeout("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr_reg

    task rd_reg(input string name, input logic [11:0] a, input logic [31:0] mask,
        input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(name, exp, r & mask);
        check({name, "_err"}, 32'(exp_err), 32'(e));
    endtask : rd_reg

    // wait for lock with the expected word on the outputs
    task wait_rx(input logic [DATA_BITS-1:0] exp);
        int n;
        n = 0;
        while (!(rx_lock === 1'b1 && rx_data === exp) && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (!(rx_lock === 1'b1 && rx_data === exp)) timeout("rx_word");
        check("rx_oe_n", 32'h0, 32'(rx_oe_n));
    endtask : wait_rx

    task wait_unlock;
        int n;
        n = 0;
        while (rx_lock !== 1'b0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (rx_lock !== 1'b0) timeout("rx_unlock");
    endtask : wait_unlock

    // find two frames on the line and check markers, parity and balance
    task frame_check(input logic [DATA_BITS-1:0] w);
        logic [83:0] b;
        logic [DATA_BITS-1:0] f;
        logic alt;
        int hits;
        hits = 0;
        alt = 1'b0;
        for (int k = 0; k < 84; k++) begin
            @(posedge clk);
            b[k] = ser_p;
        end
        for (int i = 0; i < 28; i++) begin
            for (int j = 0; j < DATA_BITS; j++) begin
                f[j] = b[i + 1 + j];
            end
            if (b[i] === 1'b1 && b[i + 27] === 1'b0 && b[i + 25] === ^f
                && (f === w || f === ~w) && b[i + 26] === (f === ~w)
                && b[i + 28] === 1'b1 && b[i + 55] === 1'b0) begin
                hits++;
                alt = b[i + 26] ^ b[i + 54];
            end
        end
        check("frame_found", 32'h1, 32'(hits > 0));
        check("balance_alternates", 32'h1, 32'(alt));
    endtask : frame_check

    // main sequence
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        supply_ok = 1'b0;
        flip = 1'b0;
        word_hi = 24'hffffff;
        word_lo = 24'hffffff;
        n_errors = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rd_reg("ctrl", ADDR_CTRL, 32'hffffffff, 32'h0, 1'b0);
        wr_reg(ADDR_CTRL, 32'h3f);
        rd_reg("ctrl", ADDR_CTRL, 32'hffffffff, 32'h3f, 1'b0);
        rd_reg("unmapped", 12'h008, 32'hffffffff, 32'h0, 1'b1);
        repeat (60) @(posedge clk);
        rd_reg("status", ADDR_STATUS, 32'h7, 32'h0, 1'b0);
        check("ser_oe_n", 32'h1, 32'(ser_oe_n));
        check("rx_lock", 32'h0, 32'(rx_lock));
        $display("test power-up done");
        supply_ok <= 1'b1;
        wait_rx(24'hffffff);
        rd_reg("status", ADDR_STATUS, 32'h7, 32'h7, 1'b0);
        frame_check(24'hffffff);
        $display("test lock and framing done");
        word_hi <= 24'h5a3c81;
        word_lo <= 24'ha5c37e;
        for (int s = 1; s >= 0; s--) begin
            wr_reg(ADDR_CTRL, 32'h3b | (32'(s) << 2));
            wait_rx(s ? 24'h5a3c81 : 24'ha5c37e);
        end
        $display("test edge select done");
        wr_reg(ADDR_CTRL, 32'h3a);
        wait_unlock();
        check("ser_oe_n", 32'h1, 32'(ser_oe_n));
        rd_reg("status", ADDR_STATUS, 32'h1, 32'h1, 1'b0);
        wr_reg(ADDR_CTRL, 32'h3b);
        wait_rx(24'ha5c37e);
        $display("test output enable done");
        @(posedge clk);
        flip <= 1'b1;
        repeat (28) @(posedge clk);
        flip <= 1'b0;
        wait_unlock();
        wait_rx(24'ha5c37e);
        $display("test resync done");
        wr_reg(ADDR_CTRL, 32'h33);
        repeat (5) @(posedge clk);
        check("rx_oe_n", 32'h1, 32'(rx_oe_n));
        check("rx_lock", 32'h1, 32'(rx_lock));
        wr_reg(ADDR_CTRL, 32'h39);
        wait_unlock();
        rd_reg("status", ADDR_STATUS, 32'h1, 32'h0, 1'b0);
        check("ser_oe_n", 32'h1, 32'(ser_oe_n));
        wr_reg(ADDR_CTRL, 32'h3b);
        wait_rx(24'ha5c37e);
        check("rx_clk", 32'h0, 32'(rx_clk));
        repeat (14) @(posedge clk);
        check("rx_clk", 32'h1, 32'(rx_clk));
        wr_reg(ADDR_CTRL, 32'h2b);
        wait_unlock();
        check("rx_oe_n", 32'h1, 32'(rx_oe_n));
        wr_reg(ADDR_CTRL, 32'h1b);
        wait_rx(24'ha5c37e);
        check("rx_clk", 32'h1, 32'(rx_clk));
        repeat (14) @(posedge clk);
        check("rx_clk", 32'h0, 32'(rx_clk));
        $display("test power-down done");
        supply_ok <= 1'b0;
        repeat (10) @(posedge clk);
        check("ser_oe_n", 32'h1, 32'(ser_oe_n));
        check("rx_lock", 32'h0, 32'(rx_lock));
        $display("test supply loss done");
        complete_run();
    end
endmodule : tb

`default_nettype wire
